//--- core/srch_consts.svh
/*
  Constants for the source range command handler: register offsets, field
  positions, reset values and range limits.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef SRCH_CONSTS_SVH
`define SRCH_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave
`define SRCH_OFF_CMD 4'h0
`define SRCH_OFF_VALUE 4'h4
`define SRCH_OFF_STAT 4'h8
`define SRCH_OFF_IRQ 4'hC
`define SRCH_ADDR_W 4

// Command register fields
`define SRCH_CMD_RANGE_LSB 0
`define SRCH_CMD_RANGE_MSB 3
`define SRCH_CMD_FUNC_VALID 4
`define SRCH_CMD_FUNC_OP 5
`define SRCH_CMD_RANGE_VALID 6
`define SRCH_CMD_SRQ_VALID 7
`define SRCH_CMD_SRQ_EN 8
`define SRCH_CMD_EXEC 9
`define SRCH_CMD_CLEAR 10

// Source value register fields: value in minimum steps, kind bit
`define SRCH_VAL_LSB 0
`define SRCH_VAL_MSB 23
`define SRCH_VAL_IS_CURRENT 24

// Status / interrupt bit positions
`define SRCH_ST_ERR 0
`define SRCH_ST_UNDER 1
`define SRCH_IRQ_W 2
`define SRCH_SPOLL_ERR_BIT 5

// Range codes
`define SRCH_RANGE_AUTO 4'h0
`define SRCH_RANGE_MAX 4'h8
`define SRCH_STANDBY_COUNTS 24'h000004

// Under-range threshold (below one minimum step of the finest range)
`define SRCH_MIN_STEP 24'h000001

// Full-scale limits in finest units (1 mV, 10 uA): volts then currents
`define SRCH_LIM_1V 24'h0003F2
`define SRCH_LIM_10V 24'h002774
`define SRCH_LIM_100V 24'h018A88
`define SRCH_LIM_100MA 24'h002774
`define SRCH_LIM_1A 24'h018A88
`define SRCH_LIM_10A 24'h0F6950

`endif

//--- core/srch_pkg.sv
/*
  Types for the source range command handler.
  Assumes srch_consts.svh is on the include path.
*/
`include "srch_consts.svh"
package srch_pkg;
  // One source value with its kind
  typedef struct packed {
    logic is_current;
    logic [23:0] value;
  } srch_value_t;

  // Decoded command word
  typedef struct packed {
    logic clear;
    logic exec;
    logic srq_en;
    logic srq_valid;
    logic range_valid;
    logic func_op;
    logic func_valid;
    logic [3:0] range;
  } srch_cmd_t;

  // Command execution states
  typedef enum logic [1:0] {SRCH_IDLE, SRCH_APPLY, SRCH_CHECK} srch_state_t;
endpackage

//--- core/srch_range_check.sv
/*
  Range checker: classifies one source value against a range code.
  Purely combinational; assumes range codes 0 (auto) to 8.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srch_consts.svh"
module srch_range_check
  import srch_pkg::*;
(
  input wire logic [3:0] range_i,
  input wire srch_value_t val_i,
  output logic over_o,
  output logic under_o,
  output logic [3:0] auto_range_o
);
  logic [23:0] vlim; // Voltage limit of the range
  logic [23:0] ilim; // Current limit of the range
  logic [23:0] lim;

  // Voltage limit by group: codes 1-3 at 1 V, 4-6 at 10 V, 7-8 at 100 V
  always_comb begin
    case (range_i)
      4'h1, 4'h2, 4'h3: vlim = `SRCH_LIM_1V;
      4'h4, 4'h5, 4'h6: vlim = `SRCH_LIM_10V;
      default: vlim = `SRCH_LIM_100V;
    endcase
  end

  // Current limit steps 100 mA, 1 A, 10 A within groups 1-3 and 4-6, and 100 mA, 1 A within 7-8
  always_comb begin
    case (range_i)
      4'h1, 4'h4, 4'h7: ilim = `SRCH_LIM_100MA;
      4'h2, 4'h5, 4'h8: ilim = `SRCH_LIM_1A;
      default: ilim = `SRCH_LIM_10A;
    endcase
  end

  // Limit for the kind of value being checked
  assign lim = val_i.is_current ? ilim : vlim;

  // Over range only on a fixed range
  assign over_o = (range_i != `SRCH_RANGE_AUTO) && (val_i.value > lim);
  assign under_o = val_i.value < `SRCH_MIN_STEP;

  // Smallest range holding the value, for auto mode
  always_comb begin
    if (val_i.is_current) begin
      if (val_i.value <= `SRCH_LIM_100MA) auto_range_o = 4'h7;
      else if (val_i.value <= `SRCH_LIM_1A) auto_range_o = 4'h8;
      else auto_range_o = 4'h6;
    end else begin
      if (val_i.value <= `SRCH_LIM_1V) auto_range_o = 4'h3;
      else if (val_i.value <= `SRCH_LIM_10V) auto_range_o = 4'h6;
      else auto_range_o = 4'h8;
    end
  end
endmodule // srch_range_check
`default_nettype wire

//--- core/srch_top.sv
/*
  Source range command handler top: Avalon-MM register slave, command
  execution, range keeping, value check, operate/standby output and
  error interrupt with serial-poll bit.
  Assumes a single 40 MHz clock; bus clear is a register write.
*/
// Design decisions made here: register access over Avalon-MM and the register addresses.
//
// Overview of operation
// - Operate command drives programmed values, lights LED
// - Range code sets voltage and current limits
// - Reset and bus clear return to auto
// - Fixed range never accepts value above limit
// - Under-range value stores zero
// - Over-range value rejected, raises error, displayed
// - Auto mode reselects range, accepts value
// - Enabled error requests service, poll bit 5
// - Standby drives plus four counts
`timescale 1ns/1ps
`default_nettype none
`include "srch_consts.svh"
module srch_top
  import srch_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [`SRCH_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  output logic srq_o,
  output logic [7:0] spoll_status_o,
  output logic operate_led_o,
  output logic error_display_o,
  output logic [3:0] range_o,
  output var srch_value_t source_out_o
);
  // Command staging and execution state
  srch_cmd_t pend_cmd; // Command staged until execute
  srch_value_t value_in; // Value waiting to be checked
  logic value_pend; // A value was written since last execute
  srch_state_t state;
  logic [3:0] range; // Active range code
  logic auto_mode; // Auto range selected
  logic operate; // Operate mode
  logic srq_en; // Service requests enabled
  srch_value_t stored; // Accepted source value
  // Event status and interrupt enables
  logic [`SRCH_IRQ_W-1:0] irq_stat; // Sticky events
  logic [`SRCH_IRQ_W-1:0] irq_mask; // Interrupt enables
  // Bus handshake and checker results
  logic ack; // Single-cycle bus acknowledge
  logic err_event; // Over-range event pulse
  logic under_event; // Under-range event pulse
  logic over; // Checker result
  logic under;
  logic [3:0] auto_rng;
  logic [3:0] chk_range;
  logic bus_wr;
  logic bus_rd;

  assign bus_wr = avs_write_i && !ack;
  assign bus_rd = avs_read_i && !ack;
  assign chk_range = auto_mode ? `SRCH_RANGE_AUTO : range;

  // Value checker against the active range
  srch_range_check srch_range_check_inst (
    .range_i(chk_range),
    .val_i(value_in),
    .over_o(over),
    .under_o(under),
    .auto_range_o(auto_rng)
  );

  // Bus acknowledge: waitrequest high until one cycle after request
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i || avs_write_i) && !ack;
    end
  end

  // Waitrequest comes from a flip-flop, low only in the acknowledge cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack);
    end
  end

  // Read data mux, registered at request capture
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (bus_rd) begin
      case (avs_address_i)
        `SRCH_OFF_CMD: avs_readdata_o <= {23'h000000, srq_en, 1'b0, auto_mode,
                                          operate, 1'b0, range};
        `SRCH_OFF_VALUE: avs_readdata_o <= {7'h00, stored};
        `SRCH_OFF_STAT: avs_readdata_o <= {24'h000000, spoll_status_o};
        `SRCH_OFF_IRQ: avs_readdata_o <= {14'h0000, irq_mask, 14'h0000, irq_stat};
        default: avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // Stage command fields and values; execution happens on the execute bit
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_cmd <= '0;
      value_in <= '0;
      value_pend <= 1'b0;
    end else begin
      if (state == SRCH_CHECK) begin
        value_pend <= 1'b0;
      end
      if (state == SRCH_APPLY) begin
        pend_cmd <= '0;
      end
      // A bus clear acts once and drops any value left unchecked
      if (pend_cmd.clear && state == SRCH_IDLE) begin
        pend_cmd <= '0;
        value_pend <= 1'b0;
      end
      if (bus_wr && avs_address_i == `SRCH_OFF_CMD && state == SRCH_IDLE) begin
        pend_cmd <= srch_cmd_t'(avs_writedata_i[10:0]);
      end
      if (bus_wr && avs_address_i == `SRCH_OFF_VALUE) begin
        value_in <= srch_value_t'(avs_writedata_i[24:0]);
        value_pend <= 1'b1;
      end
    end
  end

  // Execute sequence: apply range/function then check value, in order
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= SRCH_IDLE;
    end else begin
      case (state)
        SRCH_IDLE: if (pend_cmd.exec && !pend_cmd.clear) state <= SRCH_APPLY;
        SRCH_APPLY: state <= SRCH_CHECK;
        SRCH_CHECK: state <= SRCH_IDLE;
        default: state <= SRCH_IDLE;
      endcase
    end
  end

  // Range, function and service-request enable
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      range <= `SRCH_RANGE_AUTO;
      auto_mode <= 1'b1;
      operate <= 1'b0;
      srq_en <= 1'b0;
    end else if (pend_cmd.clear && state == SRCH_IDLE) begin
      range <= `SRCH_RANGE_AUTO;
      auto_mode <= 1'b1;
      operate <= 1'b0;
      srq_en <= 1'b0;
    end else if (state == SRCH_APPLY) begin
      if (pend_cmd.range_valid && pend_cmd.range <= `SRCH_RANGE_MAX) begin
        range <= pend_cmd.range;
        auto_mode <= (pend_cmd.range == `SRCH_RANGE_AUTO);
      end
      if (pend_cmd.func_valid) operate <= pend_cmd.func_op;
      if (pend_cmd.srq_valid) srq_en <= pend_cmd.srq_en;
    end else if (state == SRCH_CHECK && value_pend && auto_mode) begin
      range <= auto_rng;
    end
  end

  // Event pulses from the value check
  assign err_event = (state == SRCH_CHECK) && value_pend && over;
  assign under_event = (state == SRCH_CHECK) && value_pend && under && !over;

  // Stored source value: zero when under range, kept when over range
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stored <= '0;
    end else if (state == SRCH_CHECK && value_pend && !over) begin
      stored.is_current <= value_in.is_current;
      stored.value <= under ? 24'h000000 : value_in.value;
    end
  end

  // Sticky status: set wins over write-one-to-clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else begin
      for (int i = 0; i < `SRCH_IRQ_W; i++) begin
        if ((i == `SRCH_ST_ERR && err_event) || (i == `SRCH_ST_UNDER && under_event)) begin
          irq_stat[i] <= 1'b1;
        end else if (bus_wr && avs_address_i == `SRCH_OFF_IRQ && avs_writedata_i[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask in the upper half of the interrupt register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask <= '0;
    end else if (bus_wr && avs_address_i == `SRCH_OFF_IRQ) begin
      irq_mask <= avs_writedata_i[16 +: `SRCH_IRQ_W];
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      srq_o <= 1'b0;
      spoll_status_o <= 8'h00;
      operate_led_o <= 1'b0;
      error_display_o <= 1'b0;
      range_o <= `SRCH_RANGE_AUTO;
      source_out_o <= '0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
      srq_o <= srq_en && irq_stat[`SRCH_ST_ERR];
      spoll_status_o <= 8'h00;
      spoll_status_o[`SRCH_SPOLL_ERR_BIT] <= irq_stat[`SRCH_ST_ERR];
      operate_led_o <= operate;
      error_display_o <= irq_stat[`SRCH_ST_ERR];
      range_o <= range;
      if (operate) begin
        source_out_o <= stored;
      end else begin
        source_out_o.is_current <= stored.is_current;
        source_out_o.value <= `SRCH_STANDBY_COUNTS;
      end
    end
  end

  // Rejected value leaves the stored value unchanged
  a_over_keeps: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    err_event |=> $stable(stored))
    else $error("over-range value stored");

  // Under-range value is stored as zero
  a_under_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    under_event |=> stored.value == 24'h000000)
    else $error("under-range value not zero");

  // Error reaches the display two edges after the check
  a_err_display: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    err_event |=> ##1 error_display_o)
    else $error("error not displayed");

  // Error sets the sticky status bit at the end of the check
  a_err_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    err_event |=> irq_stat[`SRCH_ST_ERR])
    else $error("error status not set");

  // Enabled error raises a service request and the poll bit
  a_srq_poll: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (err_event && srq_en) |=> ##1 (srq_o && spoll_status_o[`SRCH_SPOLL_ERR_BIT]))
    else $error("no service request");

  // No service request while requests are disabled
  a_srq_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !srq_en |=> !srq_o)
    else $error("service request while disabled");

  // Auto mode never flags an over-range error
  a_auto_accept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state == SRCH_CHECK && auto_mode) |-> !err_event)
    else $error("auto range rejected value");

  // Standby drives the small fixed level; the reset edge itself is left out
  a_standby_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!rst_i && !operate) |=> source_out_o.value == `SRCH_STANDBY_COUNTS)
    else $error("standby level wrong");

  // Operate lights the indicator and drives the stored value
  a_operate_led: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    operate |=> operate_led_o && source_out_o == $past(stored))
    else $error("operate output wrong");

  // Bus clear returns to auto range, standby and requests off
  a_clear_auto: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (pend_cmd.clear && state == SRCH_IDLE) |=> range == `SRCH_RANGE_AUTO && auto_mode
      && !operate && !srq_en)
    else $error("clear not auto");

  // Execute steps through apply then check, in order
  sequence s_exec_start;
    state == SRCH_IDLE && pend_cmd.exec && !pend_cmd.clear;
  endsequence
  sequence s_apply_check;
    state == SRCH_APPLY ##1 state == SRCH_CHECK;
  endsequence
  a_exec_order: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_exec_start |=> s_apply_check)
    else $error("execute order wrong");

  // A command word written during the check step is dropped
  a_cmd_refused: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus_wr && avs_address_i == `SRCH_OFF_CMD && state == SRCH_CHECK) |=> $stable(pend_cmd))
    else $error("command accepted while busy");

  // Voltage above the 1 V limit on code 1 is an error
  a_range_group: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!auto_mode && range == 4'h1 && !value_in.is_current && value_in.value > `SRCH_LIM_1V
     && value_pend && state == SRCH_CHECK) |-> err_event)
    else $error("1 V limit not enforced");
endmodule // srch_top
`default_nettype wire

//--- verification/srch_ctrl_model.sv
/*
  Bus controller model: issues register reads and writes as an Avalon-MM master.
  Assumes one clock shared with the handler; tasks are called from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module srch_ctrl_model (
  input wire logic sys_clk_i,
  input wire logic avs_waitrequest_i,
  input wire logic [31:0] avs_readdata_i,
  output logic [3:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o
);
  // Idle bus from time zero
  initial begin
    avs_address_o <= 4'h0;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_writedata_o <= 32'h0;
  end

  // One transfer: hold request until waitrequest is seen low
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk_i);
    avs_address_o <= a;
    avs_read_o <= rd;
    avs_write_o <= !rd;
    avs_writedata_o <= d;
    do @(posedge sys_clk_i); while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b0, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    xfer(1'b1, a, 32'h0, q);
  endtask

  // Serial poll: status byte, error in bit 5
  task automatic poll(output logic [7:0] s);
    logic [31:0] q;
    xfer(1'b1, 4'h8, 32'h0, q);
    s = q[7:0];
  endtask
endmodule // srch_ctrl_model
`default_nettype wire

//--- verification/srch_top_tb.sv
/*
  Self-checking bench for the source range command handler.
  Assumes the controller model drives the register bus.
*/
`timescale 1ns/1ps
`default_nettype none
module srch_top_tb
  import srch_pkg::*;
;
  localparam logic [31:0] EX = 32'h0000_0200; // Execute
  localparam logic [31:0] RV = 32'h0000_0040; // Range valid
  localparam logic [31:0] FV = 32'h0000_0010; // Function valid
  localparam logic [31:0] OP = 32'h0000_0020; // Operate
  localparam logic [31:0] SR = 32'h0000_0180; // Service request on
  localparam logic [31:0] CL = 32'h0000_0400; // Bus clear
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] adr;
  logic rd_s, wr_s, wreq, irq, srq, led, disp;
  logic [31:0] wdat, rdat, r;
  logic [7:0] spoll, s;
  logic [3:0] rng;
  srch_value_t src;
  int n_errors = 0;
  int n_tests = 0;

  // 25 ns clock
  always #12.5 sys_clk_i = ~sys_clk_i;

  srch_top srch_top_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .irq_o(irq), .srq_o(srq), .spoll_status_o(spoll),
    .operate_led_o(led), .error_display_o(disp), .range_o(rng), .source_out_o(src));

  srch_ctrl_model srch_ctrl_model_inst (.sys_clk_i(sys_clk_i), .avs_waitrequest_i(wreq),
    .avs_readdata_i(rdat), .avs_address_o(adr), .avs_read_o(rd_s), .avs_write_o(wr_s),
    .avs_writedata_o(wdat));

  // Value comparison
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Load a value, then an executing command, and let it settle
  task automatic run(input logic [31:0] v, input logic [31:0] c);
    srch_ctrl_model_inst.wr(4'h4, v);
    srch_ctrl_model_inst.wr(4'h0, c | EX);
    repeat (6) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic t_reset;
    chk("range", 32'h0, {28'h0, rng});
    chk("waitrequest", 32'h1, {31'h0, wreq});
    chk("led", 32'h0, {31'h0, led});
    chk("irq", 32'h0, {31'h0, irq});
    $display("test reset done");
  endtask

  task automatic t_operate_error;
    srch_ctrl_model_inst.wr(4'hC, 32'h0003_0000);
    run(32'd750, RV | SR | FV | OP | 32'h3);
    chk("source", 32'd750, {7'h0, src});
    chk("led", 32'h1, {31'h0, led});
    chk("range", 32'h3, {28'h0, rng});
    run(32'd5000, 32'h0);
    chk("display", 32'h1, {31'h0, disp});
    chk("source kept", 32'd750, {7'h0, src});
    chk("srq", 32'h1, {31'h0, srq});
    chk("spoll pins", 32'h20, {24'h0, spoll});
    chk("irq", 32'h1, {31'h0, irq});
    srch_ctrl_model_inst.poll(s);
    chk("poll", 32'h20, {24'h0, s});
    srch_ctrl_model_inst.wr(4'hC, 32'h0003_0001);
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    chk("display cleared", 32'h0, {31'h0, disp});
    $display("test operate and error done");
  endtask

  // Every fixed range: voltage limit accepted, one step above refused
  task automatic t_range_table;
    logic [31:0] lim;
    for (int c = 1; c <= 8; c++) begin
      lim = (c < 4) ? 32'd1010 : (c < 7) ? 32'd10100 : 32'd101000;
      srch_ctrl_model_inst.wr(4'hC, 32'h0003_0003);
      run(lim, RV | c);
      srch_ctrl_model_inst.rd(4'hC, r);
      chk("limit ok", 32'h0, {31'h0, r[0]});
      run(lim + 32'd1, 32'h0);
      srch_ctrl_model_inst.rd(4'hC, r);
      chk("over limit", 32'h1, {31'h0, r[0]});
    end
    $display("test range table done");
  endtask

  task automatic t_under;
    srch_ctrl_model_inst.wr(4'hC, 32'h0003_0003);
    run(32'd0, RV | 32'h1);
    chk("source zero", 32'h0, {7'h0, src});
    srch_ctrl_model_inst.rd(4'hC, r);
    chk("under flag", 32'h2, {30'h0, r[1:0]});
    $display("test under range done");
  endtask

  task automatic t_auto;
    srch_ctrl_model_inst.wr(4'hC, 32'h0003_0003);
    run(32'd5000, RV);
    chk("auto group", 32'h1, {31'h0, (rng >= 4'h4) && (rng <= 4'h6)});
    chk("auto value", 32'd5000, {7'h0, src});
    chk("auto no error", 32'h0, {31'h0, disp});
    $display("test auto range done");
  endtask

  task automatic t_standby_clear;
    run(32'd5000, FV);
    chk("standby", 32'h4, {8'h0, src.value});
    chk("led off", 32'h0, {31'h0, led});
    srch_ctrl_model_inst.wr(4'h0, RV | 32'h5);
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk("no exec", 32'h1, {31'h0, rng != 4'h5});
    // Second command lands in the check step and must be dropped
    srch_ctrl_model_inst.wr(4'h0, RV | EX | 32'h2);
    srch_ctrl_model_inst.wr(4'h0, RV | EX | 32'h5);
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk("busy command dropped", 32'h2, {28'h0, rng});
    run(32'd5000, RV | 32'h1);
    chk("srq before clear", 32'h1, {31'h0, srq});
    run(32'd5000, CL);
    chk("clear range", 32'h0, {28'h0, rng});
    chk("clear srq", 32'h0, {31'h0, srq});
    srch_ctrl_model_inst.rd(4'h2, r);
    chk("unmapped", 32'h0, r);
    $display("test standby and clear done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    t_reset;
    t_operate_error;
    t_range_table;
    t_under;
    t_auto;
    t_standby_clear;
    tally_and_finish;
  end

  // Watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    tally_and_finish;
  end
endmodule // srch_top_tb
`default_nettype wire
